// ==== inc/sbs_pkg.sv ====
// Shared constants and types of the SDRAM bank state tracker.
// Assumes a single 250 MHz clock; all intervals become whole cycles here.
package sbs_pkg;

  // ==========================================================================
  // Clock and interval figures
  localparam int CLK_NS = 4;
  localparam int PRECHARGE_PERIOD_NS = 18;
  localparam int ROW_TO_COLUMN_DELAY_NS = 18;
  localparam int WRITE_RECOVERY_INTERVAL_NS = 12;
  localparam int REFRESH_CYCLE_TIME_NS = 60;
  localparam int MIN_ROW_ACTIVE_TIME_NS = 42;
  localparam int ACTIVATE_TO_ACTIVATE_DELAY_NS = 12;
  localparam int MODE_LOAD_CLOCKS = 2;

  // Least times round up to whole cycles
  localparam int PRECHARGE_PERIOD_CYC =
    (PRECHARGE_PERIOD_NS + CLK_NS - 1) / CLK_NS;
  localparam int ROW_TO_COLUMN_DELAY_CYC =
    (ROW_TO_COLUMN_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_RECOVERY_INTERVAL_CYC =
    (WRITE_RECOVERY_INTERVAL_NS + CLK_NS - 1) / CLK_NS;
  localparam int REFRESH_CYCLE_TIME_CYC =
    (REFRESH_CYCLE_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int MIN_ROW_ACTIVE_TIME_CYC =
    (MIN_ROW_ACTIVE_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACTIVATE_TO_ACTIVATE_DELAY_CYC =
    (ACTIVATE_TO_ACTIVATE_DELAY_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================================
  // Layout of the sampled pin vector
  localparam int PIN_W = 8;
  localparam int PIN_AP = 0;
  localparam int PIN_BA_LO = 1;
  localparam int PIN_WE = 3;
  localparam int PIN_CAS = 4;
  localparam int PIN_RAS = 5;
  localparam int PIN_CS = 6;
  localparam int PIN_CKE = 7;
  localparam int BA_W = 2;
  localparam int NUM_BANKS = 4;
  localparam int CNT_W = 8;
  localparam int BURST_LEN = 4;

  // ==========================================================================
  // Commands, bank states and device states
  typedef enum logic [3:0] {
    CMD_DESELECT, CMD_NOP, CMD_BURST_STOP, CMD_READ, CMD_READ_AUTOCLOSE,
    CMD_WRITE, CMD_WRITE_AUTOCLOSE, CMD_ROW_OPEN, CMD_PRECHARGE,
    CMD_ALL_BANK_PRECHARGE, CMD_REFRESH, CMD_SELF_REFRESH, CMD_MODE_LOAD
  } sbs_cmd_t;

  typedef enum logic [3:0] {
    BANK_IDLE, BANK_ACTIVATING, BANK_ACTIVE, BANK_READ, BANK_WRITE,
    BANK_READ_AP, BANK_WRITE_AP, BANK_WR_RECOVER, BANK_WR_RECOVER_AP,
    BANK_PRECHARGING
  } sbs_bank_st_t;

  typedef enum logic [2:0] {
    DEV_NORMAL, DEV_REFRESHING, DEV_MODE_ACCESS, DEV_POWER_DOWN,
    DEV_SELF_REFRESH
  } sbs_dev_st_t;

endpackage : sbs_pkg

// ==== verification/sbs_ctrl_model.sv ====
// Memory controller model that puts the chosen command onto the pins.
// Assumes the bench changes cmd shortly after each rising clock edge.
`timescale 1ns/1ps
module sbs_ctrl_model (
  // Clock
  clk,
  // Chosen command
  cmd,
  bank,
  // Command pins
  cs_n,
  ras_n,
  cas_n,
  we_n,
  ba,
  auto_precharge_bit
);
  input  wire logic              clk;
  input  wire sbs_pkg::sbs_cmd_t cmd;
  input  wire logic [1:0]        bank;
  output logic                   cs_n;
  output logic                   ras_n;
  output logic                   cas_n;
  output logic                   we_n;
  output logic [1:0]             ba;
  output logic                   auto_precharge_bit;

  logic junk_q = 1'b0;

  // ==========================================================================
  // Pin encoding
  // Don't-care pins change every cycle so that no stale level is trusted
  always @(posedge clk) begin
    junk_q <= ~junk_q;
  end

  always_comb begin
    {cs_n, ras_n, cas_n, we_n} = 4'h7;
    ba = {junk_q, ~junk_q};
    auto_precharge_bit = junk_q;
    case (cmd)
      sbs_pkg::CMD_DESELECT: {cs_n, ras_n, cas_n, we_n} = {3'h4, junk_q};
      sbs_pkg::CMD_BURST_STOP: we_n = 1'b0;
      sbs_pkg::CMD_READ, sbs_pkg::CMD_READ_AUTOCLOSE,
      sbs_pkg::CMD_WRITE, sbs_pkg::CMD_WRITE_AUTOCLOSE: begin
        cas_n = 1'b0;
        we_n = cmd inside {sbs_pkg::CMD_READ, sbs_pkg::CMD_READ_AUTOCLOSE};
        ba = bank;
        auto_precharge_bit = cmd inside {sbs_pkg::CMD_READ_AUTOCLOSE,
                                         sbs_pkg::CMD_WRITE_AUTOCLOSE};
      end
      sbs_pkg::CMD_ROW_OPEN: begin
        ras_n = 1'b0;
        ba = bank;
      end
      // No write data is driven, so none is left to mask before a precharge
      sbs_pkg::CMD_PRECHARGE, sbs_pkg::CMD_ALL_BANK_PRECHARGE: begin
        ras_n = 1'b0;
        we_n = 1'b0;
        ba = bank;
        auto_precharge_bit = cmd == sbs_pkg::CMD_ALL_BANK_PRECHARGE;
      end
      sbs_pkg::CMD_REFRESH, sbs_pkg::CMD_SELF_REFRESH: {ras_n, cas_n} = 2'h0;
      sbs_pkg::CMD_MODE_LOAD: begin
        {ras_n, cas_n, we_n} = 3'h0;
        ba = 2'h0;
        auto_precharge_bit = 1'b0;
      end
      default: ;
    endcase
  end
endmodule : sbs_ctrl_model

// ==== verification/sbs_top_bench.sv ====
// Self-checking bench for the SDRAM bank state tracker.
// Assumes the controller model turns each chosen command into pin levels.
`timescale 1ns/1ps
module sbs_top_bench;
  logic                              clk = 1'b0;
  logic                              rst_n = 1'b0;
  logic                              cke = 1'b1;
  sbs_pkg::sbs_cmd_t                 cmd = sbs_pkg::CMD_NOP;
  logic [1:0]                        bank = 2'h0;
  logic                              cs_n, ras_n, cas_n, we_n, ap;
  logic [1:0]                        ba;
  sbs_pkg::sbs_bank_st_t [3:0]       bank_state;
  logic [3:0]                        bank_illegal;
  logic                              cmd_illegal, all_idle, buffers_on;
  sbs_pkg::sbs_dev_st_t              dev_state;
  int                                fails = 0;
  int                                total_checks = 0;
  int                                cycles = 0;

  sbs_ctrl_model sbs_ctrl_model_inst (.clk(clk), .cmd(cmd), .bank(bank),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
    .auto_precharge_bit(ap));
  sbs_top sbs_top_inst (.clk(clk), .rst_n(rst_n), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
    .auto_precharge_bit(ap), .bank_state(bank_state),
    .bank_illegal(bank_illegal), .cmd_illegal(cmd_illegal),
    .all_idle(all_idle), .dev_state(dev_state), .buffers_on(buffers_on));

  always #2 clk = ~clk;

  // ==========================================================================
  // Run limit
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fails++;
      print_verdict();
    end
  end

  // ==========================================================================
  // Helpers
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Bank state for s below 4, device state for s equal to 4
  function automatic logic [3:0] obs(input int s);
    return (s < 4) ? bank_state[s] : {1'b0, dev_state};
  endfunction : obs

  task automatic nop(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask : nop

  // Two commands back to back, then a no-operation cycle
  task automatic send(input sbs_pkg::sbs_cmd_t c1, input logic [1:0] b1,
                      input sbs_pkg::sbs_cmd_t c2, input logic [1:0] b2);
    cmd = c1;
    bank = b1;
    nop(1);
    cmd = c2;
    bank = b2;
    nop(1);
    cmd = sbs_pkg::CMD_NOP;
    nop(1);
  endtask : send

  task automatic dwell(input int s, input logic [3:0] st, input int exp);
    int n;
    int w;
    n = 0;
    w = 0;
    while (obs(s) !== st && w < 40) begin
      nop(1);
      w++;
    end
    while (obs(s) === st && n < 40) begin
      nop(1);
      n++;
    end
    check("cycles in state", exp[7:0], n[7:0]);
  endtask : dwell

  task automatic expect_at(input int s, input logic [3:0] st, input int w);
    nop(w);
    check("state", {4'h0, st}, {4'h0, obs(s)});
  endtask : expect_at

  task automatic pulse(input int s, input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (10) begin
      nop(1);
      if (((s < 4) ? bank_illegal[s] : cmd_illegal) === 1'b1) begin
        seen = 1'b1;
      end
    end
    check("illegal flag", {7'h0, exp}, {7'h0, seen});
  endtask : pulse

  // ==========================================================================
  // Scenarios
  task automatic open_and_write();
    send(sbs_pkg::CMD_ROW_OPEN, 2'h0, sbs_pkg::CMD_NOP, 2'h0);
    dwell(0, sbs_pkg::BANK_ACTIVATING, 5);
    check("all idle", 8'h00, {7'h0, all_idle});
    expect_at(1, sbs_pkg::BANK_IDLE, 0);
    send(sbs_pkg::CMD_ROW_OPEN, 2'h2, sbs_pkg::CMD_READ, 2'h2);
    pulse(2, 1'b1);
    send(sbs_pkg::CMD_WRITE, 2'h0, sbs_pkg::CMD_NOP, 2'h0);
    dwell(0, sbs_pkg::BANK_WRITE, 4);
    dwell(0, sbs_pkg::BANK_WR_RECOVER, 3);
    expect_at(0, sbs_pkg::BANK_ACTIVE, 0);
    send(sbs_pkg::CMD_WRITE, 2'h0, sbs_pkg::CMD_NOP, 2'h0);
    nop(3);
    send(sbs_pkg::CMD_WRITE, 2'h0, sbs_pkg::CMD_NOP, 2'h0);
    pulse(0, 1'b0);
    send(sbs_pkg::CMD_WRITE_AUTOCLOSE, 2'h0, sbs_pkg::CMD_NOP, 2'h0);
    nop(3);
    send(sbs_pkg::CMD_BURST_STOP, 2'h0, sbs_pkg::CMD_NOP, 2'h0);
    expect_at(0, sbs_pkg::BANK_ACTIVE, 12);
    send(sbs_pkg::CMD_READ, 2'h0, sbs_pkg::CMD_DESELECT, 2'h0);
    dwell(0, sbs_pkg::BANK_READ, 4);
    expect_at(0, sbs_pkg::BANK_ACTIVE, 0);
  endtask : open_and_write

  task automatic autoclose();
    send(sbs_pkg::CMD_READ_AUTOCLOSE, 2'h0, sbs_pkg::CMD_NOP, 2'h0);
    dwell(0, sbs_pkg::BANK_READ_AP, 4);
    dwell(0, sbs_pkg::BANK_PRECHARGING, 5);
    expect_at(0, sbs_pkg::BANK_IDLE, 0);
    send(sbs_pkg::CMD_WRITE_AUTOCLOSE, 2'h2, sbs_pkg::CMD_PRECHARGE, 2'h2);
    pulse(2, 1'b1);
    expect_at(2, sbs_pkg::BANK_IDLE, 10);
    send(sbs_pkg::CMD_ROW_OPEN, 2'h1, sbs_pkg::CMD_NOP, 2'h1);
    nop(8);
    send(sbs_pkg::CMD_WRITE_AUTOCLOSE, 2'h1, sbs_pkg::CMD_NOP, 2'h1);
    dwell(1, sbs_pkg::BANK_WRITE_AP, 4);
    dwell(1, sbs_pkg::BANK_WR_RECOVER_AP, 3);
    dwell(1, sbs_pkg::BANK_PRECHARGING, 5);
  endtask : autoclose

  task automatic spacing();
    send(sbs_pkg::CMD_ROW_OPEN, 2'h1, sbs_pkg::CMD_ROW_OPEN, 2'h3);
    pulse(4, 1'b1);
    send(sbs_pkg::CMD_ROW_OPEN, 2'h0, sbs_pkg::CMD_NOP, 2'h0);
    nop(5);
    send(sbs_pkg::CMD_PRECHARGE, 2'h0, sbs_pkg::CMD_NOP, 2'h0);
    pulse(0, 1'b1);
    send(sbs_pkg::CMD_ALL_BANK_PRECHARGE, 2'h0, sbs_pkg::CMD_NOP, 2'h0);
    dwell(1, sbs_pkg::BANK_PRECHARGING, 5);
    nop(10);
    for (int b = 0; b < 4; b++) begin
      expect_at(b, sbs_pkg::BANK_IDLE, 0);
    end
    check("all idle", 8'h01, {7'h0, all_idle});
  endtask : spacing

  task automatic device_modes();
    send(sbs_pkg::CMD_REFRESH, 2'h0, sbs_pkg::CMD_NOP, 2'h0);
    dwell(4, sbs_pkg::DEV_REFRESHING, 15);
    send(sbs_pkg::CMD_REFRESH, 2'h0, sbs_pkg::CMD_ROW_OPEN, 2'h1);
    pulse(4, 1'b1);
    nop(10);
    send(sbs_pkg::CMD_MODE_LOAD, 2'h0, sbs_pkg::CMD_BURST_STOP, 2'h0);
    pulse(4, 1'b1);
    send(sbs_pkg::CMD_MODE_LOAD, 2'h0, sbs_pkg::CMD_NOP, 2'h0);
    dwell(4, sbs_pkg::DEV_MODE_ACCESS, 2);
    cke = 1'b0;
    expect_at(4, sbs_pkg::DEV_POWER_DOWN, 8);
    check("buffers on", 8'h00, {7'h0, buffers_on});
    send(sbs_pkg::CMD_ROW_OPEN, 2'h0, sbs_pkg::CMD_NOP, 2'h0);
    expect_at(0, sbs_pkg::BANK_IDLE, 8);
    cke = 1'b1;
    expect_at(4, sbs_pkg::DEV_NORMAL, 12);
    check("buffers on", 8'h01, {7'h0, buffers_on});
    cke = 1'b0;
    cmd = sbs_pkg::CMD_SELF_REFRESH;
    nop(1);
    cmd = sbs_pkg::CMD_NOP;
    expect_at(4, sbs_pkg::DEV_SELF_REFRESH, 8);
    check("buffers on", 8'h00, {7'h0, buffers_on});
    cke = 1'b1;
    dwell(4, sbs_pkg::DEV_REFRESHING, 15);
  endtask : device_modes

  initial begin
    nop(6);
    rst_n = 1'b1;
    nop(12);
    open_and_write();
    autoclose();
    spacing();
    device_modes();
    print_verdict();
  end
endmodule : sbs_top_bench

// ==== verilog/sbs_bank.sv ====
// One bank's state machine with its interval and burst counters.
// Assumes decoded, registered commands from the same clock domain.
`timescale 1ns/1ps
module sbs_bank #(
  parameter int CW  = sbs_pkg::CNT_W,
  parameter int BL  = sbs_pkg::BURST_LEN,
  parameter int RCD = sbs_pkg::ROW_TO_COLUMN_DELAY_CYC,
  parameter int RP  = sbs_pkg::PRECHARGE_PERIOD_CYC,
  parameter int DPL = sbs_pkg::WRITE_RECOVERY_INTERVAL_CYC,
  parameter int RAS = sbs_pkg::MIN_ROW_ACTIVE_TIME_CYC
) (
  // Clock and synchronised reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Decoded command
  input  wire logic                  cmd_valid,
  input  wire sbs_pkg::sbs_cmd_t     cmd,
  input  wire logic                  hit,
  // Bank status
  output sbs_pkg::sbs_bank_st_t      bank_state,
  output logic                       illegal
);

  typedef struct packed {
    sbs_pkg::sbs_bank_st_t st;
    logic [CW-1:0]         cnt;
    logic [CW-1:0]         ras;
    logic                  keep_open;
    logic                  illegal;
  } sbs_bank_reg_t;

  sbs_bank_reg_t q;
  sbs_bank_reg_t d;
  logic          done;
  logic          mine;
  logic          col;
  logic          pre;
  logic          act;
  logic          burst_stop_cmd;

  // ==========================================================================
  // Next state
  always_comb begin
    d = q;
    d.illegal = 1'h0;
    done = (q.cnt == '0);
    mine = cmd_valid && hit;
    col = mine && (cmd inside {sbs_pkg::CMD_READ,
      sbs_pkg::CMD_READ_AUTOCLOSE, sbs_pkg::CMD_WRITE,
      sbs_pkg::CMD_WRITE_AUTOCLOSE});
    pre = mine && (cmd inside {sbs_pkg::CMD_PRECHARGE,
      sbs_pkg::CMD_ALL_BANK_PRECHARGE});
    act = mine && (cmd == sbs_pkg::CMD_ROW_OPEN);
    burst_stop_cmd = mine && (cmd == sbs_pkg::CMD_BURST_STOP);
    if (!done) begin
      d.cnt = q.cnt - CW'(1);
    end
    if (q.ras != '0) begin
      d.ras = q.ras - CW'(1);
    end
    unique case (q.st)
      sbs_pkg::BANK_IDLE: begin
        if (act) begin
          d.st = sbs_pkg::BANK_ACTIVATING;
          d.cnt = CW'(RCD - 1);
          d.ras = CW'(RAS);
        end else if (col) begin
          d.illegal = 1'h1;
        end
      end
      sbs_pkg::BANK_ACTIVATING: begin
        d.illegal = col || act || pre;
        if (done) begin
          d.st = sbs_pkg::BANK_ACTIVE;
        end
      end
      sbs_pkg::BANK_ACTIVE, sbs_pkg::BANK_READ, sbs_pkg::BANK_WRITE,
      sbs_pkg::BANK_WR_RECOVER: begin
        if (col) begin
          d.cnt = CW'(BL - 1);
          unique case (cmd)
            sbs_pkg::CMD_READ:           d.st = sbs_pkg::BANK_READ;
            sbs_pkg::CMD_READ_AUTOCLOSE: d.st = sbs_pkg::BANK_READ_AP;
            sbs_pkg::CMD_WRITE:          d.st = sbs_pkg::BANK_WRITE;
            default:                     d.st = sbs_pkg::BANK_WRITE_AP;
          endcase
        end else if (act || (pre && q.st == sbs_pkg::BANK_WR_RECOVER)) begin
          d.illegal = 1'h1;
        end else if (pre) begin
          if (q.ras != '0) begin
            d.illegal = 1'h1;
          end else begin
            d.st = sbs_pkg::BANK_PRECHARGING;
            d.cnt = CW'(RP - 1);
          end
        end else if (burst_stop_cmd && q.st != sbs_pkg::BANK_WR_RECOVER) begin
          d.st = sbs_pkg::BANK_ACTIVE;
        end else if (done && q.st == sbs_pkg::BANK_WRITE) begin
          d.st = sbs_pkg::BANK_WR_RECOVER;
          d.cnt = CW'(DPL - 1);
        end else if (done && q.st != sbs_pkg::BANK_ACTIVE) begin
          d.st = sbs_pkg::BANK_ACTIVE;
        end
      end
      sbs_pkg::BANK_READ_AP, sbs_pkg::BANK_WRITE_AP: begin
        d.illegal = col || act || pre || burst_stop_cmd;
        d.keep_open = 1'h0;
        if (done && q.st == sbs_pkg::BANK_READ_AP) begin
          d.st = sbs_pkg::BANK_PRECHARGING;
          d.cnt = CW'(RP - 1);
        end else if (done) begin
          d.st = sbs_pkg::BANK_WR_RECOVER_AP;
          d.cnt = CW'(DPL - 1);
        end
      end
      sbs_pkg::BANK_WR_RECOVER_AP: begin
        d.illegal = col || act || pre;
        d.keep_open = q.keep_open || burst_stop_cmd;
        if (done) begin
          d.st = d.keep_open ? sbs_pkg::BANK_ACTIVE
                             : sbs_pkg::BANK_PRECHARGING;
          d.cnt = CW'(RP - 1);
        end
      end
      sbs_pkg::BANK_PRECHARGING: begin
        d.illegal = col || act;
        if (done) begin
          d.st = sbs_pkg::BANK_IDLE;
        end
      end
      default: begin
        d.st = sbs_pkg::BANK_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{st: sbs_pkg::BANK_IDLE, cnt: '0, ras: '0, keep_open: 1'h0,
             illegal: 1'h0};
    end else begin
      q <= d;
    end
  end

  assign bank_state = q.st;
  assign illegal = q.illegal;

  // ==========================================================================
  // Checks
  localparam int RP_C = RP;
  localparam int RCD_C = RCD;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_enter_pre;
    q.st == sbs_pkg::BANK_PRECHARGING &&
      $past(q.st) != sbs_pkg::BANK_PRECHARGING;
  endsequence
  sequence s_enter_act;
    q.st == sbs_pkg::BANK_ACTIVATING && $past(q.st) == sbs_pkg::BANK_IDLE;
  endsequence

  a_precharge_idle: assert property (s_enter_pre |-> ##RP_C
    q.st == sbs_pkg::BANK_IDLE) else $error("precharge length wrong");
  a_activate_open: assert property (s_enter_act |-> ##RCD_C
    q.st == sbs_pkg::BANK_ACTIVE) else $error("activation length wrong");
  a_read_ap_close: assert property (q.st == sbs_pkg::BANK_READ_AP && done
    |=> q.st == sbs_pkg::BANK_PRECHARGING)
    else $error("read autoclose did not precharge");
  a_write_ap_recov: assert property (q.st == sbs_pkg::BANK_WRITE_AP && done
    |=> q.st == sbs_pkg::BANK_WR_RECOVER_AP)
    else $error("write autoclose skipped recovery");
  a_ap_col_illegal: assert property (q.st == sbs_pkg::BANK_READ_AP && col
    |=> q.illegal) else $error("column command to closing bank");
  a_recover_active: assert property (q.st == sbs_pkg::BANK_WR_RECOVER &&
    done && !col && !act && !pre |=> q.st == sbs_pkg::BANK_ACTIVE)
    else $error("write recovery did not end");
  a_recap_end: assert property (q.st == sbs_pkg::BANK_WR_RECOVER_AP && done
    |=> q.st == ($past(q.keep_open || burst_stop_cmd) ? sbs_pkg::BANK_ACTIVE
                                            : sbs_pkg::BANK_PRECHARGING))
    else $error("recovery with autoclose ended wrong");
  a_early_close: assert property (q.st == sbs_pkg::BANK_ACTIVE && pre &&
    q.ras != '0 |=> q.illegal && q.st == sbs_pkg::BANK_ACTIVE)
    else $error("early precharge not refused");

endmodule : sbs_bank

// ==== verilog/sbs_top.sv ====
// SDRAM command decode, device-wide states and per-bank state tracking.
// Assumes the controller drives every pin from this same 250 MHz clock.
`timescale 1ns/1ps

// What this block does
// - Read autoclose finishes burst, then precharges
// - Write autoclose finishes burst, then recovers, closes
// - Precharging ignores commands, idle after period
// - Activating ignores commands, active after delay
// - Write recovery ends in row active
// - Column commands allowed in recovery; no activate/precharge
// - Recovery autoclose precharges, unless burst stop
// - Refresh allows only idle commands and burst stop, ends after cycle
// - Mode load allows only idle commands, two clocks
// - Decode only when clock enable high twice
// - Idle and clock enable low: power down
// - Idle, enable low with refresh: self refresh
// - Autoclose bit picks one bank or all
// - Autoclose bit on column command closes row
module sbs_top #(
  parameter int NB  = sbs_pkg::NUM_BANKS,
  parameter int BAW = sbs_pkg::BA_W,
  parameter int CW  = sbs_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // Command pins
  input  wire logic                       cke,
  input  wire logic                       cs_n,
  input  wire logic                       ras_n,
  input  wire logic                       cas_n,
  input  wire logic                       we_n,
  input  wire logic [BAW-1:0]             ba,
  input  wire logic                       auto_precharge_bit,
  // Status
  output sbs_pkg::sbs_bank_st_t [NB-1:0]  bank_state,
  output logic [NB-1:0]                   bank_illegal,
  output logic                            cmd_illegal,
  output logic                            all_idle,
  output sbs_pkg::sbs_dev_st_t            dev_state,
  output logic                            buffers_on
);

  localparam int PW = sbs_pkg::PIN_W;

  typedef struct packed {
    logic [PW-1:0]        s1;
    logic [PW-1:0]        s2;
    logic [PW-1:0]        acc;
    logic                 cke_prev;
    logic                 cmd_valid;
    sbs_pkg::sbs_cmd_t    cmd;
    logic [BAW-1:0]       bank;
    sbs_pkg::sbs_dev_st_t gstate;
    logic [CW-1:0]        gcnt;
    logic [CW-1:0]        rrd;
    logic                 illegal;
    logic                 all_idle;
    logic                 buffers_on;
  } sbs_top_reg_t;

  sbs_top_reg_t      q;
  sbs_top_reg_t      d;
  logic              rst_meta_q;
  logic              rst_sync_n;
  logic [NB-1:0]     idle_now;
  logic              idle_all;
  logic              cke_now;
  logic              cmd_en;
  logic              idle_cmd;
  sbs_pkg::sbs_cmd_t dec;

  // ==========================================================================
  // Reset release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'h0;
      rst_sync_n <= 1'h0;
    end else begin
      rst_meta_q <= 1'h1;
      rst_sync_n <= rst_meta_q;
    end
  end

  // ==========================================================================
  // Banks
  genvar gi;
  for (gi = 0; gi < NB; gi++) begin : g_bank
    sbs_bank #(
      .CW (CW)
    ) u_bank (
      .clk        (clk),
      .rst_n      (rst_sync_n),
      .cmd_valid  (q.cmd_valid && q.gstate == sbs_pkg::DEV_NORMAL),
      .cmd        (q.cmd),
      .hit        (q.cmd inside {sbs_pkg::CMD_ALL_BANK_PRECHARGE,
                    sbs_pkg::CMD_BURST_STOP} ||
                   q.bank == BAW'(gi)),
      .bank_state (bank_state[gi]),
      .illegal    (bank_illegal[gi])
    );
    assign idle_now[gi] = (bank_state[gi] == sbs_pkg::BANK_IDLE);
  end

  // ==========================================================================
  // Decode and device state
  always_comb begin
    d = q;
    idle_all = &idle_now;
    // Same-clock pins pass a plain three-stage register: no filtering,
    // so every pin cycle counts as exactly one command
    d.s1 = {cke, cs_n, ras_n, cas_n, we_n, ba, auto_precharge_bit};
    d.s2 = q.s1;
    d.acc = q.s2;
    cke_now = q.acc[sbs_pkg::PIN_CKE];
    d.cke_prev = cke_now;
    cmd_en = q.cke_prev && cke_now;
    if (q.acc[sbs_pkg::PIN_CS]) begin
      dec = sbs_pkg::CMD_DESELECT;
    end else begin
      unique case (q.acc[sbs_pkg::PIN_RAS:sbs_pkg::PIN_WE])
        3'h7: dec = sbs_pkg::CMD_NOP;
        3'h6: dec = sbs_pkg::CMD_BURST_STOP;
        3'h5: dec = q.acc[sbs_pkg::PIN_AP] ? sbs_pkg::CMD_READ_AUTOCLOSE
                                           : sbs_pkg::CMD_READ;
        3'h4: dec = q.acc[sbs_pkg::PIN_AP] ? sbs_pkg::CMD_WRITE_AUTOCLOSE
                                           : sbs_pkg::CMD_WRITE;
        3'h3: dec = sbs_pkg::CMD_ROW_OPEN;
        3'h2: dec = q.acc[sbs_pkg::PIN_AP] ? sbs_pkg::CMD_ALL_BANK_PRECHARGE
                                           : sbs_pkg::CMD_PRECHARGE;
        3'h1: dec = cke_now ? sbs_pkg::CMD_REFRESH
                            : sbs_pkg::CMD_SELF_REFRESH;
        default: dec = sbs_pkg::CMD_MODE_LOAD;
      endcase
    end
    idle_cmd = dec inside {sbs_pkg::CMD_DESELECT, sbs_pkg::CMD_NOP};
    d.cmd_valid = cmd_en;
    d.cmd = dec;
    d.bank = q.acc[sbs_pkg::PIN_BA_LO +: BAW];
    d.illegal = 1'h0;
    d.all_idle = idle_all;
    if (q.gcnt != '0) begin
      d.gcnt = q.gcnt - CW'(1);
    end
    if (q.rrd != '0) begin
      d.rrd = q.rrd - CW'(1);
    end
    unique case (q.gstate)
      sbs_pkg::DEV_NORMAL: begin
        if (q.cke_prev && !cke_now && idle_all) begin
          d.gstate = (dec == sbs_pkg::CMD_SELF_REFRESH)
                   ? sbs_pkg::DEV_SELF_REFRESH
                   : sbs_pkg::DEV_POWER_DOWN;
        end else if (cmd_en && dec == sbs_pkg::CMD_ROW_OPEN) begin
          d.illegal = (q.rrd != '0);
          d.rrd = CW'(sbs_pkg::ACTIVATE_TO_ACTIVATE_DELAY_CYC - 1);
        end else if (cmd_en && dec == sbs_pkg::CMD_REFRESH) begin
          d.illegal = !idle_all;
          if (idle_all) begin
            d.gstate = sbs_pkg::DEV_REFRESHING;
            d.gcnt = CW'(sbs_pkg::REFRESH_CYCLE_TIME_CYC - 1);
          end
        end else if (cmd_en && dec == sbs_pkg::CMD_MODE_LOAD) begin
          d.illegal = !idle_all;
          if (idle_all) begin
            d.gstate = sbs_pkg::DEV_MODE_ACCESS;
            d.gcnt = CW'(sbs_pkg::MODE_LOAD_CLOCKS - 1);
          end
        end
      end
      sbs_pkg::DEV_REFRESHING: begin
        d.illegal = cmd_en && !idle_cmd &&
                    dec != sbs_pkg::CMD_BURST_STOP;
        if (q.gcnt == '0) begin
          d.gstate = sbs_pkg::DEV_NORMAL;
        end
      end
      sbs_pkg::DEV_MODE_ACCESS: begin
        d.illegal = cmd_en && !idle_cmd;
        if (q.gcnt == '0) begin
          d.gstate = sbs_pkg::DEV_NORMAL;
        end
      end
      sbs_pkg::DEV_POWER_DOWN: begin
        if (!q.cke_prev && cke_now) begin
          d.gstate = sbs_pkg::DEV_NORMAL;
        end
      end
      default: begin
        if (!q.cke_prev && cke_now) begin
          d.gstate = sbs_pkg::DEV_REFRESHING;
          d.gcnt = CW'(sbs_pkg::REFRESH_CYCLE_TIME_CYC - 1);
        end
      end
    endcase
    d.buffers_on = !(d.gstate inside {sbs_pkg::DEV_POWER_DOWN,
                     sbs_pkg::DEV_SELF_REFRESH});
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      q <= '{s1: '0, s2: '0, acc: '0, cke_prev: 1'h0,
             cmd_valid: 1'h0, cmd: sbs_pkg::CMD_DESELECT, bank: '0,
             gstate: sbs_pkg::DEV_NORMAL, gcnt: '0, rrd: '0,
             illegal: 1'h0, all_idle: 1'h1, buffers_on: 1'h1};
    end else begin
      q <= d;
    end
  end

  assign cmd_illegal = q.illegal;
  assign all_idle = q.all_idle;
  assign dev_state = q.gstate;
  assign buffers_on = q.buffers_on;

  // ==========================================================================
  // Checks
  localparam int RC_C = sbs_pkg::REFRESH_CYCLE_TIME_CYC;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  sequence s_mode_start;
    q.gstate == sbs_pkg::DEV_MODE_ACCESS &&
      $past(q.gstate) == sbs_pkg::DEV_NORMAL;
  endsequence
  sequence s_ref_start;
    q.gstate == sbs_pkg::DEV_REFRESHING &&
      $past(q.gstate) == sbs_pkg::DEV_NORMAL;
  endsequence

  a_mode_two_clk: assert property (s_mode_start |-> ##2
    q.gstate == sbs_pkg::DEV_NORMAL) else $error("mode load not 2 clocks");
  a_refresh_cycle: assert property (s_ref_start |-> ##RC_C
    q.gstate == sbs_pkg::DEV_NORMAL) else $error("refresh length wrong");
  a_cke_gating: assert property (q.cmd_valid |->
    $past(q.acc[sbs_pkg::PIN_CKE] && q.cke_prev))
    else $error("command decoded with clock enable low");
  a_pd_buffers: assert property (q.gstate == sbs_pkg::DEV_POWER_DOWN |->
    !q.buffers_on) else $error("buffers on in power down");
  a_self_entry: assert property ($rose(q.gstate ==
    sbs_pkg::DEV_SELF_REFRESH) |-> $past(idle_all) && !q.buffers_on)
    else $error("self refresh entered while busy");
  a_ref_illegal: assert property (q.gstate == sbs_pkg::DEV_REFRESHING &&
    cmd_en && dec == sbs_pkg::CMD_ROW_OPEN |=> q.illegal)
    else $error("activate during refresh not flagged");

endmodule : sbs_top
